// ===== rtl/nvm_pkg.sv
package nvm_pkg;
    localparam int          MEM_WORDS     = 32768;
    localparam int          ADDR_W        = 15;
    localparam int          DATA_W        = 8;
    localparam logic [3:0]  DEV_TYPE      = 4'h6; // arbitrary type code
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  ACK_SLOT      = 4'h9;
    localparam logic [14:0] ADDR_LAST     = 15'h7FFF;
    localparam logic [14:0] ADDR_FIRST    = 15'h0000;
    // apb map
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS    = 8'h04;
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam int          ST_BUSY_BIT   = 16;
    localparam int          ST_WP_BIT     = 17;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_DEVADR = 7'h02,
        ST_ADRHI  = 7'h04,
        ST_ADRLO  = 7'h08,
        ST_WDATA  = 7'h10,
        ST_RDATA  = 7'h20,
        ST_IGNORE = 7'h40
    } state_t;
endpackage

// ===== rtl/nvm_i2c_slave.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nvm_i2c_slave (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // straps
    input  wire logic [2:0]  device_select_pins,
    input  wire logic        write_protect
);
    // pin synchronisers, pins pulled low externally when open
    logic [2:0]  pins_s1_q, pins_s2_q;
    logic        scl_s1_q, scl_s2_q, scl_s3_q;
    logic        sda_s1_q, sda_s2_q, sda_s3_q;
    logic        wp_s1_q, wp_s2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_s1_q <= 3'h0;
            pins_s2_q <= 3'h0;
            scl_s1_q  <= 1'b1;
            scl_s2_q  <= 1'b1;
            scl_s3_q  <= 1'b1;
            sda_s1_q  <= 1'b1;
            sda_s2_q  <= 1'b1;
            sda_s3_q  <= 1'b1;
            wp_s1_q   <= 1'b0;
            wp_s2_q   <= 1'b0;
        end else begin
            pins_s1_q <= device_select_pins;
            pins_s2_q <= pins_s1_q;
            scl_s1_q  <= scl_i;
            scl_s2_q  <= scl_s1_q;
            scl_s3_q  <= scl_s2_q;
            sda_s1_q  <= sda_i;
            sda_s2_q  <= sda_s1_q;
            sda_s3_q  <= sda_s2_q;
            wp_s1_q   <= write_protect;
            wp_s2_q   <= wp_s1_q;
        end
    end

    // bus events; scl is only ever an input here
    wire scl_rise  = scl_s2_q & ~scl_s3_q;
    wire scl_fall  = ~scl_s2_q & scl_s3_q;
    wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    nvm_pkg::state_t state_q, state_d;
    logic [3:0]  cnt_q;
    logic [7:0]  rx_q;
    logic [7:0]  tx_q;
    logic [14:0] addr_q;
    logic [6:0]  addr_hi_q;
    logic        mack_q;
    logic        sda_oe_q;
    logic        en_q;
    logic [7:0]  mem_q [nvm_pkg::MEM_WORDS];

    wire byte_done = scl_fall & (cnt_q == nvm_pkg::BITS_PER_BYTE);
    wire ack_done  = scl_fall & (cnt_q == nvm_pkg::ACK_SLOT);
    wire in_read   = (state_q == nvm_pkg::ST_RDATA);
    wire code_hit  = (rx_q[7:4] == nvm_pkg::DEV_TYPE)
                   & (rx_q[3:1] == pins_s2_q) & en_q;
    // fetch a byte to send after a read device word and after each read byte the master acks, never after a write one
    wire load_rd   = ack_done & (((state_q == nvm_pkg::ST_DEVADR) & rx_q[0])
                                 | (in_read & mack_q));
    wire mem_we    = byte_done & (state_q == nvm_pkg::ST_WDATA)
                   & ~wp_s2_q;
    wire addr_inc  = load_rd | (byte_done & (state_q == nvm_pkg::ST_WDATA));
    wire [7:0] rd_byte = mem_q[addr_q];
    wire [2:0] tx_idx  = 3'(4'h7 - cnt_q);

    // state transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            nvm_pkg::ST_IDLE:   state_d = nvm_pkg::ST_IDLE;
            nvm_pkg::ST_DEVADR: begin
                if (byte_done && !code_hit) begin
                    state_d = nvm_pkg::ST_IGNORE;
                end else if (ack_done) begin
                    state_d = rx_q[0] ? nvm_pkg::ST_RDATA
                                      : nvm_pkg::ST_ADRHI;
                end
            end
            nvm_pkg::ST_ADRHI:  if (ack_done) state_d = nvm_pkg::ST_ADRLO;
            nvm_pkg::ST_ADRLO:  if (ack_done) state_d = nvm_pkg::ST_WDATA;
            nvm_pkg::ST_WDATA:  state_d = nvm_pkg::ST_WDATA;
            nvm_pkg::ST_RDATA:  if (ack_done && !mack_q) state_d = nvm_pkg::ST_IGNORE;
            nvm_pkg::ST_IGNORE: state_d = nvm_pkg::ST_IGNORE;
            default:            state_d = nvm_pkg::ST_IDLE;
        endcase
        if (start_det) begin
            state_d = nvm_pkg::ST_DEVADR;
        end
        if (stop_det) begin
            state_d = nvm_pkg::ST_IDLE;
        end
    end

    // serial engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= nvm_pkg::ST_IDLE;
            cnt_q     <= 4'h0;
            rx_q      <= 8'h00;
            tx_q      <= 8'h00;
            addr_q    <= nvm_pkg::ADDR_FIRST;
            addr_hi_q <= 7'h00;
            mack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_det || stop_det) begin
                cnt_q    <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (cnt_q < nvm_pkg::BITS_PER_BYTE) begin
                    rx_q <= {rx_q[6:0], sda_s2_q};
                end else begin
                    mack_q <= ~sda_s2_q;
                end
                cnt_q <= cnt_q + 4'h1;
            end else if (byte_done) begin
                // ack slot: receiver pulls low, transmitter lets go
                sda_oe_q <= ~in_read & (state_q != nvm_pkg::ST_IGNORE)
                          & ((state_q != nvm_pkg::ST_DEVADR) | code_hit);
            end else if (ack_done) begin
                cnt_q    <= 4'h0;
                sda_oe_q <= load_rd ? ~rd_byte[7] : 1'b0;
            end else if (scl_fall && in_read && cnt_q != 4'h0) begin
                sda_oe_q <= ~tx_q[tx_idx];
            end
            if (load_rd) begin
                tx_q <= rd_byte;
            end
            if (byte_done && state_q == nvm_pkg::ST_ADRHI) begin
                addr_hi_q <= rx_q[6:0];
            end
            if (byte_done && state_q == nvm_pkg::ST_ADRLO) begin
                addr_q <= {addr_hi_q, rx_q};
            end else if (addr_inc) begin
                addr_q <= addr_q + 15'h0001;
            end
        end
    end

    // array written at the start of the ack slot, no busy time after
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem_q[addr_q] <= rx_q;
        end
    end

    // apb slave, one wait state
    wire       apb_access = psel & penable;
    wire       hit_ctrl   = (paddr == nvm_pkg::CTRL_OFS);
    wire       hit_stat   = (paddr == nvm_pkg::STATUS_OFS);
    wire       apb_done   = apb_access & pready;
    wire [31:0] rd_mux    = hit_ctrl ? {31'h0, en_q}
                          : hit_stat ? {14'h0, wp_s2_q, (state_q != nvm_pkg::ST_IDLE),
                                        1'b0, addr_q}
                          : 32'h0;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
            en_q      <= nvm_pkg::CTRL_EN_RST;
        end else begin
            pready_q  <= apb_access & ~pready_q;
            pslverr_q <= apb_access & ~pready_q & ~hit_ctrl & ~hit_stat;
            prdata_q  <= (apb_access & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
            if (apb_done && pwrite && hit_ctrl) begin
                en_q <= pwdata[nvm_pkg::CTRL_EN_BIT];
            end
        end
    end

    logic sda_o_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign sda_o   = sda_o_q;
    assign sda_oe  = sda_oe_q;

    property p_open_drain;
        @(posedge pclk) disable iff (!presetn)
        sda_oe |-> (sda_o == 1'b0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");

    property p_mismatch;
        @(posedge pclk) disable iff (!presetn)
        (byte_done && state_q == nvm_pkg::ST_DEVADR
            && rx_q[3:1] != pins_s2_q && !start_det && !stop_det)
        |=> (state_q == nvm_pkg::ST_IGNORE) && !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not ignored");

    property p_ignore_quiet;
        @(posedge pclk) disable iff (!presetn)
        (state_q == nvm_pkg::ST_IGNORE) |-> !sda_oe;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("driven while ignoring");

    property p_oe_on_fall;
        @(posedge pclk) disable iff (!presetn)
        $changed(sda_oe) |-> $past(scl_fall || start_det || stop_det);
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("data changed off fall");

    property p_wp_block;
        @(posedge pclk) disable iff (!presetn)
        (wp_s2_q && byte_done && state_q == nvm_pkg::ST_WDATA)
        |-> !mem_we ##1 (mem_q[$past(addr_q)] == $past(rd_byte));
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("write under protect");

    property p_stop_idle;
        @(posedge pclk) disable iff (!presetn)
        stop_det |=> (state_q == nvm_pkg::ST_IDLE) && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

    property p_ack_drive;
        @(posedge pclk) disable iff (!presetn)
        (byte_done && (state_q == nvm_pkg::ST_ADRHI || state_q == nvm_pkg::ST_ADRLO)
            && !start_det && !stop_det)
        |=> sda_oe [*1] ##1 (sda_oe || scl_fall || ack_done || stop_det);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("address byte not acked");

    property p_dir;
        @(posedge pclk) disable iff (!presetn)
        (ack_done && state_q == nvm_pkg::ST_DEVADR && !start_det && !stop_det)
        |=> (state_q == ($past(rx_q[0]) ? nvm_pkg::ST_RDATA : nvm_pkg::ST_ADRHI));
    endproperty
    a_dir: assert property (p_dir) else $error("wrong direction");

    property p_addr_load;
        @(posedge pclk) disable iff (!presetn)
        (byte_done && state_q == nvm_pkg::ST_ADRLO)
        |=> addr_q == {$past(addr_hi_q), $past(rx_q)};
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("bad address load");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (addr_inc && addr_q == nvm_pkg::ADDR_LAST)
        |=> addr_q == nvm_pkg::ADDR_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");
endmodule
`default_nettype wire

// ===== dv/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // clock
    input  wire logic pclk,
    // serial bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // each clock phase of a data bit lasts 4 pclk, so scl runs at 200 ns
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // data set mid low phase, line read at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        wt(2);
        sda_m <= b;
        wt(2);
        scl <= 1'b1;
        wt(4);
        r = sda;
    endtask

    // a then b while scl high: (1,0) is a start, (0,1) a stop
    task automatic cond(input logic a, input logic b);
        scl <= 1'b0;
        wt(2);
        sda_m <= a;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_m <= b;
        wt(4);
    endtask

    // byte msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(ack_in, r);
        ack = (r === 1'b0);
    endtask
endmodule
`default_nettype wire

// ===== dv/i2c_nonvolatile_byte_memory_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_nonvolatile_byte_memory_slave_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, rx;
    logic [31:0] pwdata, prdata, rd;
    logic        scl, sda_m, sda_o, sda_oe, wp, er, ak;
    logic [2:0]  pins;
    wire logic   sda;
    int          error_cnt, num_checks, seed, ptr;
    logic [7:0]  mem_m [int];

    // open drain wire with pull-up
    assign sda = sda_m & ~(sda_oe & ~sda_o);

    always #12.5 pclk = ~pclk;

    nvm_i2c_slave dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .device_select_pins(pins), .write_protect(wp));
    i2c_master_model m_u (.pclk(pclk), .sda(sda), .scl(scl), .sda_m(sda_m));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t bus access timed out", $time);
            report_and_stop();
        end
    endtask

    task automatic dev(input logic [6:0] code, input logic rw, input logic exp);
        m_u.cond(1'b1, 1'b0);
        m_u.xfer({code, rw}, 1'b1, rx, ak);
        chk(32'(ak), 32'(exp), "device word ack");
    endtask

    task automatic adr(input logic [14:0] a);
        dev({nvm_pkg::DEV_TYPE, pins}, 1'b0, 1'b1);
        // top bit of the high byte is always sent as zero
        m_u.xfer({1'b0, a[14:8]}, 1'b1, rx, ak);
        chk(32'(ak), 1, "address high ack");
        m_u.xfer(a[7:0], 1'b1, rx, ak);
        chk(32'(ak), 1, "address low ack");
        ptr = int'(a);
    endtask

    task automatic wr(input logic [14:0] a, input int n);
        logic [7:0] d;
        adr(a);
        repeat (n) begin
            d = 8'($random(seed));
            m_u.xfer(d, 1'b1, rx, ak);
            chk(32'(ak), 1, "data ack");
            if (wp === 1'b0)
                mem_m[ptr] = d;
            ptr = (ptr + 1) % nvm_pkg::MEM_WORDS;
        end
        m_u.cond(1'b0, 1'b1);
    endtask

    // current address read when cur is set, random read otherwise
    task automatic rdn(input logic cur, input logic [14:0] a, input int n);
        if (!cur)
            adr(a);
        dev({nvm_pkg::DEV_TYPE, pins}, 1'b1, 1'b1);
        for (int k = 0; k < n; k++) begin
            m_u.xfer(8'hFF, k == n - 1, rx, ak);
            chk(32'(rx), 32'(mem_m[ptr]), "read data");
            ptr = (ptr + 1) % nvm_pkg::MEM_WORDS;
        end
        m_u.cond(1'b0, 1'b1);
    endtask

    always @(posedge pclk)
        if (sda_oe === 1'b1)
            chk(32'(sda_o), 0, "data line driven high");

    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        $display("BAD %0t run too long", $time);
        report_and_stop();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, wp, pins} = '0;
        {error_cnt, num_checks, ptr} = '0;
        seed = 82609;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pins <= 3'($random(seed));
        repeat (4) @(posedge pclk);
        apb(1'b0, nvm_pkg::CTRL_OFS, 32'h0);
        chk(32'(rd[nvm_pkg::CTRL_EN_BIT]), 1, "enable reset value");
        apb(1'b0, nvm_pkg::STATUS_OFS, 32'h0);
        chk(32'({rd[17:16], rd[14:0]}), 0, "status reset value");
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        chk(32'(er), 1, "unmapped write error");
        $display("test registers finished");
        for (int c = 0; c < 8; c++) begin
            dev({nvm_pkg::DEV_TYPE, 3'(c)}, 1'b0, 3'(c) == pins);
            m_u.cond(1'b0, 1'b1);
        end
        dev({~nvm_pkg::DEV_TYPE, pins}, 1'b0, 1'b0);
        m_u.cond(1'b0, 1'b1);
        apb(1'b1, nvm_pkg::CTRL_OFS, 32'h0);
        dev({nvm_pkg::DEV_TYPE, pins}, 1'b0, 1'b0);
        m_u.cond(1'b0, 1'b1);
        apb(1'b1, nvm_pkg::CTRL_OFS, 32'h1);
        $display("test address match finished");
        wr(15'h7FFE, 4);
        rdn(1'b0, 15'h7FFE, 4);
        apb(1'b0, nvm_pkg::STATUS_OFS, 32'h0);
        chk(32'(rd[14:0]), 32'(ptr), "address counter");
        $display("test wrap finished");
        wp <= 1'b1;
        wr(15'h7FFF, 2);
        rdn(1'b1, 15'h0, 1);
        apb(1'b0, nvm_pkg::STATUS_OFS, 32'h0);
        chk(32'(rd[17]), 1, "protect status");
        rdn(1'b0, 15'h7FFF, 2);
        wp <= 1'b0;
        ptr = $random(seed);
        wr(15'(ptr), 3);
        rdn(1'b0, 15'(ptr - 3), 3);
        $display("test protect finished");
        report_and_stop();
    end
endmodule
`default_nettype wire
